// >>> hdl/wrsf_defines.svh
// Function
// RULE1 - four modes, two formats, display unaffected
// RULE2 - direct mode: flush, ^C, monitor, echo, convers, start
// RULE3 - controller modes report averages every 60 samples
// RULE4 - flag, date, time, then c s g t fields
// RULE5 - then P and r rain, project tag ends
// RULE6 - direct controller mode runs at 4800 baud
// RULE7 - auxiliary mode: same reports, no init sequence
// RULE8 - raw mode: every sample, 9600, no init
// RULE9 - raw report omits gust field, otherwise identical
// RULE10 - boot: running clock button loads local clock
// RULE11 - gauge absent at boot: ignore rain, no errors
// RULE12 - format change sets default baud, override later
// RULE13 - three-digit zero padded fields, ends with CR
`ifndef WRSF_DEFINES_SVH
`define WRSF_DEFINES_SVH

// core clock and serial rates
`define WRSF_CLK_HZ      100000000
`define WRSF_BAUD_LO     2400
`define WRSF_BAUD_MID    4800
`define WRSF_BAUD_HI     9600

// averaging period in five second samples
`define WRSF_AVG_SAMPLES 60
// largest value a three digit field can carry
`define WRSF_FIELD_MAX   10'd999

// report and init string lengths in bytes
`define WRSF_LEN_CTRL    6'd37
`define WRSF_LEN_RAW     6'd33
`define WRSF_LEN_INIT    6'd52
// first byte index after flag, date and time
`define WRSF_HDR_LEN     6'd9

// characters
`define WRSF_CH_FLAG     8'h5f
`define WRSF_CH_CR       8'h0d
`define WRSF_CH_ZERO     8'h30
// field tag letters in controller order c s g t P r
`define WRSF_TAGS        "csgtPr"
// project tag and terminator
`define WRSF_TRAILER     {"e1w", 8'h0d}
// controller init: flush, ^C, monitor off, echo off, convers, start message
`define WRSF_INIT_TEXT   {8'h0d, 8'h03, "MONITOR OFF", 8'h0d, "ECHO OFF", 8'h0d, \
                          "CONVERS", 8'h0d, "WEATHER START 1.00.0", 8'h0d}

`endif

// >>> hdl/wrsf_pkg.sv
package wrsf_pkg;
  // reporting modes
  typedef enum logic [1:0] {
    WRSF_DIRECT = 2'b00,
    WRSF_AUX    = 2'b01,
    WRSF_RAW    = 2'b10,
    WRSF_EMUL   = 2'b11
  } wrsf_mode_e;
  // serial rate selection, code 2'b11 unused
  typedef enum logic [1:0] {
    WRSF_B2400 = 2'b00,
    WRSF_B4800 = 2'b01,
    WRSF_B9600 = 2'b10
  } wrsf_baud_e;
  // report sequencer
  typedef enum logic [1:0] {
    WRSF_IDLE = 2'b00,
    WRSF_INIT = 2'b01,
    WRSF_WAIT = 2'b10,
    WRSF_SEND = 2'b11
  } wrsf_state_e;
endpackage

// >>> hdl/wrsf_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module wrsf_uart_tx (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] div_in,
  input  wire logic        valid_in,
  input  wire logic [7:0]  data_in,
  output logic             ready_out,
  output logic             tx_out
);
  logic [9:0]  shf;       // frame shift register, lsb on the line
  logic [9:0]  next_shf;
  logic [3:0]  nbit;      // bits still to send, zero when idle
  logic [3:0]  next_nbit;
  logic [15:0] cnt;       // cycles left in the current bit
  logic [15:0] next_cnt;

  // 8n1 framer; divisor is sampled per bit so a rate change lands cleanly
  always_comb begin
    next_shf  = shf;
    next_nbit = nbit;
    next_cnt  = cnt;
    if (nbit == 4'd0) begin
      // idle: load start, data, stop
      if (valid_in) begin
        next_shf  = {1'b1, data_in, 1'b0};
        next_nbit = 4'd10;
        next_cnt  = div_in - 16'd1;
      end
    end else if (cnt == 16'd0) begin
      // bit time over: shift in idle ones behind the frame
      next_shf  = {1'b1, shf[9:1]};
      next_nbit = nbit - 4'd1;
      next_cnt  = div_in - 16'd1;
    end else begin
      next_cnt = cnt - 16'd1;
    end
  end

  // registers only; line idles high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shf  <= 10'h3ff;
      nbit <= 4'h0;
      cnt  <= 16'h0000;
    end else begin
      shf  <= next_shf;
      nbit <= next_nbit;
      cnt  <= next_cnt;
    end
  end

  assign ready_out = (nbit == 4'd0);
  assign tx_out    = shf[0];

  default clocking ucb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_uart_idle_high: assert property (ready_out |-> tx_out) // RULE13
    else $error("line not idle high");
  a_uart_start_low: assert property (valid_in && ready_out |=> !tx_out && !ready_out) // RULE13
    else $error("start bit missing");
  a_uart_stop_high: assert property ((nbit == 4'd1) |-> tx_out) // RULE13
    else $error("stop bit not high");
endmodule
`default_nettype wire

// >>> hdl/wrsf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrsf_defines.svh"
module wrsf_top #(
  parameter int DIV_LO  = `WRSF_CLK_HZ / `WRSF_BAUD_LO,
  parameter int DIV_MID = `WRSF_CLK_HZ / `WRSF_BAUD_MID,
  parameter int DIV_HI  = `WRSF_CLK_HZ / `WRSF_BAUD_HI
) (
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RSTN_IN,
  input  wire logic [1:0] MODE_IN,
  input  wire logic       BAUD_SET_IN,
  input  wire logic [1:0] BAUD_SEL_IN,
  input  wire logic       RUN_IN,
  input  wire logic       SAMPLE_IN,
  input  wire logic [9:0] WDIR_IN,
  input  wire logic [9:0] WSPD_IN,
  input  wire logic [9:0] TEMP_IN,
  input  wire logic [9:0] RAIN_DAY_IN,
  input  wire logic [9:0] RAIN_HOUR_IN,
  input  wire logic       RAIN_ERR_IN,
  input  wire logic       RAIN_PRESENT_IN,
  input  wire logic       BTN_PRESENT_IN,
  input  wire logic       BTN_RUNNING_IN,
  input  wire logic [3:0] TIME_MON_IN,
  input  wire logic [4:0] TIME_DAY_IN,
  input  wire logic [4:0] TIME_HOUR_IN,
  input  wire logic [5:0] TIME_MIN_IN,
  input  wire logic       SET_TIME_IN,
  input  wire logic       MINUTE_IN,
  output logic            TXD_OUT,
  output logic [1:0]      BAUD_OUT,
  output logic            TIME_FROM_BTN_OUT,
  output logic            RAIN_MISSING_OUT,
  output logic [5:0]      RAIN_ERRS_OUT,
  output logic [6:0]      SAMPLE_NUM_OUT,
  output logic            BUSY_OUT
);
  localparam logic [6:0] LAST_SMP = 7'(`WRSF_AVG_SAMPLES - 1);
  // text held as vectors so that single bytes can be picked by index
  localparam logic [47:0]  TAGS      = `WRSF_TAGS;
  localparam logic [31:0]  TRAILER   = `WRSF_TRAILER;
  localparam logic [415:0] INIT_TEXT = `WRSF_INIT_TEXT;

  // three digit clamp; negative temperatures are not representable here
  function automatic logic [9:0] clamp(input logic [15:0] v);
    clamp = (v > {6'h00, `WRSF_FIELD_MAX}) ? `WRSF_FIELD_MAX : v[9:0];
  endfunction
  function automatic logic [9:0] avg(input logic [15:0] v);
    avg = clamp(v / 16'(`WRSF_AVG_SAMPLES));
  endfunction
  function automatic logic [9:0] mx(input logic [9:0] a, input logic [9:0] b);
    mx = (a > b) ? a : b;
  endfunction
  // one ascii digit of a three digit field, p=1 hundreds
  function automatic logic [7:0] dig3(input logic [9:0] v, input logic [1:0] p);
    logic [9:0] d;
    if (p == 2'd1) d = v / 10'd100;
    else if (p == 2'd2) d = (v / 10'd10) % 10'd10;
    else d = v % 10'd10;
    dig3 = `WRSF_CH_ZERO + d[7:0];
  endfunction
  // one ascii digit of a two digit date or time field
  function automatic logic [7:0] dig2(input logic [5:0] v, input logic hi);
    logic [5:0] d;
    d = hi ? (v / 6'd10) : (v % 6'd10);
    dig2 = `WRSF_CH_ZERO + {2'b00, d};
  endfunction
  function automatic wrsf_pkg::wrsf_baud_e dflt(input logic [1:0] m);
    if (m == wrsf_pkg::WRSF_DIRECT) dflt = wrsf_pkg::WRSF_B4800;
    else if (m == wrsf_pkg::WRSF_RAW) dflt = wrsf_pkg::WRSF_B9600;
    else dflt = wrsf_pkg::WRSF_B2400;
  endfunction

  // reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ---- power-up, rate and local clock state ----
  logic                 booted, next_booted;       // first cycle after reset done
  logic                 fbtn, next_fbtn;           // time came from clock button
  logic                 rmiss, next_rmiss;         // gauge absent since boot
  logic [5:0]           rerr, next_rerr;           // rain error counter, wraps
  logic [1:0]           mode_q, next_mode_q;       // last mode seen
  wrsf_pkg::wrsf_baud_e baud, next_baud;
  logic [3:0]           cmon, next_cmon;           // local utc clock
  logic [4:0]           cday, next_cday;
  logic [4:0]           chr, next_chr;
  logic [5:0]           cmin, next_cmin;

  always_comb begin
    next_booted = 1'b1;
    next_fbtn   = fbtn;
    next_rmiss  = rmiss;
    next_rerr   = rerr;
    next_mode_q = MODE_IN;
    next_baud   = baud;
    next_cmon   = cmon;
    next_cday   = cday;
    next_chr    = chr;
    next_cmin   = cmin;
    if (!booted) begin
      // straps caught once; only a new reset rereads them
      next_rmiss = ~RAIN_PRESENT_IN; // RULE11
      next_fbtn  = BTN_PRESENT_IN & BTN_RUNNING_IN; // RULE10
      if (BTN_PRESENT_IN && BTN_RUNNING_IN) begin
        next_cmon = TIME_MON_IN; // RULE10
        next_cday = TIME_DAY_IN;
        next_chr  = TIME_HOUR_IN;
        next_cmin = TIME_MIN_IN;
      end
    end else if (SET_TIME_IN) begin
      // manual set
      next_cmon = TIME_MON_IN;
      next_cday = TIME_DAY_IN;
      next_chr  = TIME_HOUR_IN;
      next_cmin = TIME_MIN_IN;
    end else if (MINUTE_IN) begin
      // minute and hour roll; date roll is left to whoever sets the clock
      if (cmin == 6'd59) begin
        next_cmin = 6'd0;
        next_chr  = (chr == 5'd23) ? 5'd0 : chr + 5'd1;
      end else begin
        next_cmin = cmin + 6'd1;
      end
    end
    // a missing gauge never counts errors
    if (booted && RAIN_ERR_IN && !rmiss) begin
      next_rerr = rerr + 6'd1; // RULE11
    end
    // explicit rate choice wins over the default in the same cycle
    if (BAUD_SET_IN && BAUD_SEL_IN != 2'b11) begin
      next_baud = wrsf_pkg::wrsf_baud_e'(BAUD_SEL_IN); // RULE12
    end else if (MODE_IN != mode_q) begin
      next_baud = dflt(MODE_IN); // RULE12
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      booted <= 1'b0;
      fbtn   <= 1'b0;
      rmiss  <= 1'b0;
      rerr   <= 6'h00;
      mode_q <= wrsf_pkg::WRSF_DIRECT;
      baud   <= wrsf_pkg::WRSF_B4800;
      cmon   <= 4'h1;
      cday   <= 5'h01;
      chr    <= 5'h00;
      cmin   <= 6'h00;
    end else begin
      booted <= next_booted;
      fbtn   <= next_fbtn;
      rmiss  <= next_rmiss;
      rerr   <= next_rerr;
      mode_q <= next_mode_q;
      baud   <= next_baud;
      cmon   <= next_cmon;
      cday   <= next_cday;
      chr    <= next_chr;
      cmin   <= next_cmin;
    end
  end

  // bit divisor from the selected rate
  logic [15:0] div;
  always_comb begin
    unique case (baud)
      wrsf_pkg::WRSF_B4800: div = 16'(DIV_MID); // RULE6
      wrsf_pkg::WRSF_B9600: div = 16'(DIV_HI); // RULE8
      default:              div = 16'(DIV_LO);
    endcase
  end

  // ---- report sequencer, averaging and field latches ----
  wrsf_pkg::wrsf_state_e st, next_st;
  logic [5:0]  idx, next_idx;        // byte within the string being sent
  logic        pend, next_pend;      // a latched report waits to go out
  logic        fraw, next_fraw;      // latched report is the raw layout
  logic        run_q, next_run_q;
  logic [15:0] acc_d, next_acc_d;    // period sums
  logic [15:0] acc_s, next_acc_s;
  logic [15:0] acc_t, next_acc_t;
  logic [9:0]  gust, next_gust;      // peak speed in the period
  logic [6:0]  nsmp, next_nsmp;
  logic [9:0]  fld [0:5];            // c s g t P r values as sent
  logic [9:0]  next_fld [0:5];
  logic [19:0] tsnap, next_tsnap;    // {mon,day,hour,min} at latch
  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic        take, smp, ctrl, rset, rclr;
  logic [9:0]  r_day, r_hour;

  assign ctrl     = (MODE_IN == wrsf_pkg::WRSF_DIRECT) || // RULE1
                    (MODE_IN == wrsf_pkg::WRSF_AUX);
  assign tx_valid = (st == wrsf_pkg::WRSF_INIT) || (st == wrsf_pkg::WRSF_SEND);
  assign take     = tx_valid && tx_ready;
  // samples count only while reports may be produced
  assign smp      = SAMPLE_IN && (st == wrsf_pkg::WRSF_WAIT || st == wrsf_pkg::WRSF_SEND);
  assign r_day    = rmiss ? 10'h000 : clamp({6'h00, RAIN_DAY_IN}); // RULE11
  assign r_hour   = rmiss ? 10'h000 : clamp({6'h00, RAIN_HOUR_IN});

  always_comb begin
    next_st    = st;
    next_idx   = idx;
    next_fraw  = fraw;
    next_run_q = RUN_IN;
    next_acc_d = acc_d;
    next_acc_s = acc_s;
    next_acc_t = acc_t;
    next_gust  = gust;
    next_nsmp  = nsmp;
    next_fld   = fld;
    next_tsnap = tsnap;
    rset = 1'b0;
    rclr = 1'b0;
    unique case (st)
      wrsf_pkg::WRSF_IDLE: begin
        rclr = 1'b1;
        if (RUN_IN && !run_q) begin
          next_idx   = 6'd0;
          next_nsmp  = 7'd0;
          next_acc_d = 16'h0000;
          next_acc_s = 16'h0000;
          next_acc_t = 16'h0000;
          next_gust  = 10'h000;
          // only the direct controller needs the init commands
          next_st = (MODE_IN == wrsf_pkg::WRSF_DIRECT) ? // RULE2 RULE7 RULE8
                    wrsf_pkg::WRSF_INIT : wrsf_pkg::WRSF_WAIT;
        end
      end
      wrsf_pkg::WRSF_INIT: begin
        if (take) begin
          if (idx == `WRSF_LEN_INIT - 6'd1) begin
            next_st  = wrsf_pkg::WRSF_WAIT;
            next_idx = 6'd0;
          end else begin
            next_idx = idx + 6'd1; // RULE2
          end
        end
      end
      wrsf_pkg::WRSF_WAIT: begin
        if (pend) begin
          rclr     = 1'b1;
          next_st  = wrsf_pkg::WRSF_SEND;
          next_idx = 6'd0;
        end
      end
      wrsf_pkg::WRSF_SEND: begin
        if (take) begin
          if (idx == (fraw ? `WRSF_LEN_RAW : `WRSF_LEN_CTRL) - 6'd1) begin
            next_st  = wrsf_pkg::WRSF_WAIT;
            next_idx = 6'd0;
          end else begin
            next_idx = idx + 6'd1;
          end
        end
      end
    endcase
    if (smp && ctrl) begin
      if (nsmp == LAST_SMP) begin
        // period complete: average including this sample
        next_fld[0] = avg(acc_d + {6'h00, WDIR_IN}); // RULE3
        next_fld[1] = avg(acc_s + {6'h00, WSPD_IN});
        next_fld[2] = clamp({6'h00, mx(gust, WSPD_IN)});
        next_fld[3] = avg(acc_t + {6'h00, TEMP_IN});
        next_acc_d  = 16'h0000;
        next_acc_s  = 16'h0000;
        next_acc_t  = 16'h0000;
        next_gust   = 10'h000;
        next_nsmp   = 7'd0;
        rset        = 1'b1;
      end else begin
        next_acc_d = acc_d + {6'h00, WDIR_IN};
        next_acc_s = acc_s + {6'h00, WSPD_IN};
        next_acc_t = acc_t + {6'h00, TEMP_IN};
        next_gust  = mx(gust, WSPD_IN);
        next_nsmp  = nsmp + 7'd1;
      end
    end
    if (smp && MODE_IN == wrsf_pkg::WRSF_RAW) begin
      // every sample goes out as it is
      next_fld[0] = clamp({6'h00, WDIR_IN}); // RULE8
      next_fld[1] = clamp({6'h00, WSPD_IN});
      next_fld[3] = clamp({6'h00, TEMP_IN});
      rset        = 1'b1;
    end
    // emulation samples are not framed by this block
    if (rset) begin
      next_fld[4] = r_day; // RULE5
      next_fld[5] = r_hour;
      next_fraw   = (MODE_IN == wrsf_pkg::WRSF_RAW); // RULE9
      next_tsnap  = {cmon, cday, chr, cmin};
    end
    if (!RUN_IN) next_st = wrsf_pkg::WRSF_IDLE;
    // a new report in the cycle its predecessor is taken is kept
    next_pend = rset || (pend && !rclr);
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st    <= wrsf_pkg::WRSF_IDLE;
      idx   <= 6'h00;
      pend  <= 1'b0;
      fraw  <= 1'b0;
      run_q <= 1'b0;
      acc_d <= 16'h0000;
      acc_s <= 16'h0000;
      acc_t <= 16'h0000;
      gust  <= 10'h000;
      nsmp  <= 7'h00;
      fld   <= '{default: 10'h000};
      tsnap <= 20'h00000;
    end else begin
      st    <= next_st;
      idx   <= next_idx;
      pend  <= next_pend;
      fraw  <= next_fraw;
      run_q <= next_run_q;
      acc_d <= next_acc_d;
      acc_s <= next_acc_s;
      acc_t <= next_acc_t;
      gust  <= next_gust;
      nsmp  <= next_nsmp;
      fld   <= next_fld;
      tsnap <= next_tsnap;
    end
  end

  // ---- byte generator for init and report strings ----
  logic [5:0] off, pm, iinv;
  logic [2:0] fsel, nslot;
  logic [1:0] tt;
  logic [5:0] tv;
  always_comb begin
    off   = idx - `WRSF_HDR_LEN;
    pm    = idx - 6'd1;
    iinv  = `WRSF_LEN_INIT - 6'd1 - idx;
    nslot = fraw ? 3'd5 : 3'd6;
    fsel  = 3'd0;
    tt    = 2'd0;
    unique case (pm[2:1])
      2'd0: tv = {2'b00, tsnap[19:16]};
      2'd1: tv = {1'b0, tsnap[15:11]};
      2'd2: tv = {1'b0, tsnap[10:6]};
      2'd3: tv = tsnap[5:0];
    endcase
    if (st == wrsf_pkg::WRSF_INIT) begin
      tx_byte = INIT_TEXT[{iinv, 3'b000} +: 8]; // RULE2
    end else if (idx == 6'd0) begin
      tx_byte = `WRSF_CH_FLAG; // RULE4
    end else if (idx < `WRSF_HDR_LEN) begin
      tx_byte = dig2(tv, ~pm[0]); // RULE4
    end else if (off[5:2] < {1'b0, nslot}) begin
      // raw layout skips the gust slot
      fsel = (fraw && off[4:2] >= 3'd2) ? off[4:2] + 3'd1 : off[4:2]; // RULE9
      if (off[1:0] == 2'd0) tx_byte = TAGS[{3'(3'd5 - fsel), 3'b000} +: 8];
      else tx_byte = dig3(fld[fsel], off[1:0]); // RULE13
    end else begin
      tt      = off[1:0];
      tx_byte = TRAILER[{2'(2'd3 - tt), 3'b000} +: 8]; // RULE5 RULE13
    end
  end

  wrsf_uart_tx u_tx (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (rst_n),
    .div_in    (div),
    .valid_in  (tx_valid),
    .data_in   (tx_byte),
    .ready_out (tx_ready),
    .tx_out    (TXD_OUT)
  );

  // status outputs, all from flops except busy
  assign BAUD_OUT          = baud;
  assign TIME_FROM_BTN_OUT = fbtn;
  assign RAIN_MISSING_OUT  = rmiss;
  assign RAIN_ERRS_OUT     = rerr;
  assign SAMPLE_NUM_OUT    = nsmp;
  assign BUSY_OUT          = tx_valid || !tx_ready;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!rst_n);

  sequence s_start_direct;
    st == wrsf_pkg::WRSF_IDLE && RUN_IN && !run_q && MODE_IN == wrsf_pkg::WRSF_DIRECT;
  endsequence
  sequence s_start_other;
    st == wrsf_pkg::WRSF_IDLE && RUN_IN && !run_q && MODE_IN != wrsf_pkg::WRSF_DIRECT;
  endsequence

  a_init_order: assert property (s_start_direct |=> st == wrsf_pkg::WRSF_INIT // RULE2
      && idx == 6'd0 && tx_byte == `WRSF_CH_CR) else $error("init not started");
  a_init_etx: assert property (st == wrsf_pkg::WRSF_INIT && idx == 6'd1 |-> tx_byte == 8'h03) // RULE2
    else $error("control-c not second");
  a_aux_noinit: assert property (s_start_other |=> st == wrsf_pkg::WRSF_WAIT) // RULE7
    else $error("init sent outside direct mode");
  a_avg_period: assert property (smp && ctrl && nsmp == LAST_SMP |=> pend && nsmp == 7'd0) // RULE3
    else $error("period end missed");
  a_smp_bound: assert property (nsmp <= LAST_SMP) // RULE3
    else $error("sample count overran");
  a_flag_first: assert property (st == wrsf_pkg::WRSF_SEND && idx == 6'd0 |-> tx_byte == 8'h5f) // RULE4
    else $error("report flag missing");
  a_gust_slot: assert property (st == wrsf_pkg::WRSF_SEND && idx == 6'd17 // RULE9
      |-> tx_byte == (fraw ? 8'h74 : 8'h67)) else $error("gust slot wrong");
  a_report_end: assert property (st == wrsf_pkg::WRSF_SEND && take // RULE13
      && next_st == wrsf_pkg::WRSF_WAIT |-> tx_byte == `WRSF_CH_CR)
    else $error("report not ended by cr");
  a_rain_quiet: assert property (rmiss |=> $stable(rerr) && fld[4] == 10'h000) // RULE11
    else $error("rain used while gauge missing");
  a_btn_load: assert property (!booted && BTN_PRESENT_IN && BTN_RUNNING_IN // RULE10
      |=> fbtn && cmin == $past(TIME_MIN_IN)) else $error("clock not loaded");
  a_baud_dflt: assert property (MODE_IN != mode_q && !BAUD_SET_IN // RULE12
      |=> baud == dflt($past(MODE_IN))) else $error("default rate not applied");
endmodule
`default_nettype wire

// >>> tb/wrsf_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
// far-end serial receiver, 8N1 lsb first, samples mid bit
module wrsf_uart_rx (
  input  wire logic        clk_in,
  input  wire logic        line_in,
  input  wire logic [15:0] div_in,
  output logic [7:0]       byte_out,
  output logic             strobe_out
);
  logic [7:0] shift; // bits gathered so far; outputs stay unknown until the first byte
  // behavioural frame capture; a bad stop bit drops the byte so counts expose it
  always begin
    @(negedge line_in);
    repeat (div_in / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (div_in) @(posedge clk_in);
      shift[i] = line_in;
    end
    repeat (div_in) @(posedge clk_in);
    if (line_in === 1'b1) begin
      byte_out   <= shift;
      strobe_out <= 1'b1;
      @(posedge clk_in);
      strobe_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/weather_report_serial_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
module weather_report_serial_framer_test;
  logic        clk = 1'b0;                   // core clock
  logic        rstn = 1'b0;                  // board reset, low active
  logic [1:0]  mode = 2'b00;                 // report mode
  logic        bset = 1'b0;                  // rate override strobe
  logic [1:0]  bsel = 2'b00;                 // override code
  logic        run = 1'b0, smp = 1'b0;       // display active, sample strobe
  logic [9:0]  dir = 10'd270, spd = 10'h000; // wind inputs
  logic [9:0]  tmp = 10'd72;                 // temperature
  logic [9:0]  rday = 10'd12, rhr = 10'd3;   // rain inputs
  logic        rerr = 1'b0, rpres = 1'b0;    // rain error pulse, gauge fitted
  logic        bpres = 1'b0, brun = 1'b0;    // clock button state
  logic [3:0]  mon = 4'd3;                   // boot time 03/14 05:07
  logic [4:0]  day = 5'd14, hr = 5'd5;
  logic [5:0]  mn = 6'd7;
  logic        stime = 1'b0;                 // manual time load
  logic        tick = 1'b0;                  // minute strobe
  logic        txd, tbtn, rmiss, busy;       // design outputs
  logic [1:0]  baud;
  logic [5:0]  rerrs;
  logic [6:0]  snum;
  logic [15:0] rxdiv = 16'd4;                // receiver bit length in cycles
  logic [7:0]  rx_byte;
  logic        rx_stb;
  logic [7:0]  rxq[$];                       // bytes seen on the line
  int          errors = 0, checks_done = 0;
  // rate table rows: {mode, expected rate code}
  logic [3:0]  rows [4] = '{4'b0100, 4'b1010, 4'b1100, 4'b0001};
  // small divisors keep the run short: 2400 -> 8, 4800 -> 4, 9600 -> 2
  wrsf_top #(.DIV_LO(8), .DIV_MID(4), .DIV_HI(2)) dut (
    .CORE_CLK_IN(clk), .RSTN_IN(rstn), .MODE_IN(mode), .BAUD_SET_IN(bset),
    .BAUD_SEL_IN(bsel), .RUN_IN(run), .SAMPLE_IN(smp), .WDIR_IN(dir),
    .WSPD_IN(spd), .TEMP_IN(tmp), .RAIN_DAY_IN(rday), .RAIN_HOUR_IN(rhr),
    .RAIN_ERR_IN(rerr), .RAIN_PRESENT_IN(rpres), .BTN_PRESENT_IN(bpres),
    .BTN_RUNNING_IN(brun), .TIME_MON_IN(mon), .TIME_DAY_IN(day),
    .TIME_HOUR_IN(hr), .TIME_MIN_IN(mn), .SET_TIME_IN(stime), .MINUTE_IN(tick),
    .TXD_OUT(txd), .BAUD_OUT(baud), .TIME_FROM_BTN_OUT(tbtn),
    .RAIN_MISSING_OUT(rmiss), .RAIN_ERRS_OUT(rerrs), .SAMPLE_NUM_OUT(snum),
    .BUSY_OUT(busy)
  );
  wrsf_uart_rx far (
    .clk_in(clk), .line_in(txd), .div_in(rxdiv), .byte_out(rx_byte), .strobe_out(rx_stb)
  );
  always #5 clk = ~clk;
  // gather received bytes
  always @(posedge clk) if (rx_stb === 1'b1) rxq.push_back(rx_byte);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // boot levels must stay put well past the internal reset release
  task automatic boot(input logic rp, input logic br);
    rstn = 1'b0;
    rpres = rp;
    bpres = br;
    brun = br;
    cyc(4);
    rstn = 1'b1;
    cyc(6);
  endtask
  task automatic pulse_rerr;
    rerr = 1'b1;
    cyc(1);
    rerr = 1'b0;
    cyc(2);
  endtask
  task automatic sample(input logic [9:0] s);
    spd = s;
    smp = 1'b1;
    cyc(1);
    smp = 1'b0;
    cyc(3);
  endtask
  // one averaging period with speeds 0..59: mean 29, gust 59
  task automatic period;
    for (int i = 0; i < 60; i++) begin
      sample(10'(i));
      if (i == 9) check(16'(snum), 16'd10);
    end
  endtask
  // waits, bounded, for the whole text, then insists on exact length
  task automatic expect_text(input string s);
    int w;
    w = 0;
    while (rxq.size() < s.len() && w < 20000) begin
      cyc(1);
      w++;
    end
    for (int i = 0; i < s.len(); i++)
      check(i < rxq.size() ? {8'h00, rxq[i]} : 16'hffff, {8'h00, s[i]});
    cyc(200);
    check(16'(rxq.size()), 16'(s.len()));
    rxq.delete();
  endtask
  function automatic string rep(input bit g, input int m, d, h, mi, sp, gu, c, p, r);
    string s;
    s = $sformatf("_%02d%02d%02d%02dc%03ds%03d", m, d, h, mi, c, sp);
    if (g) s = {s, $sformatf("g%03d", gu)};
    return {s, $sformatf("t%03dP%03dr%03de1w", 72, p, r), "\015"};
  endfunction
  // watchdog: whole run needs well under this
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    boot(1'b0, 1'b1); // gauge missing, button clock running
    check(16'(txd), 16'h1);
    check(16'(baud), 16'h1);
    check(16'(busy), 16'h0);
    check(16'(tbtn), 16'h1);
    check(16'(rmiss), 16'h1);
    pulse_rerr();
    check(16'(rerrs), 16'h0);
    for (int i = 0; i < 4; i++) begin
      mode = rows[i][3:2];
      cyc(2);
      check(16'(baud), 16'(rows[i][1:0]));
    end
    // an unused override code is refused, a real one wins
    bsel = 2'b11;
    bset = 1'b1;
    cyc(1);
    bset = 1'b0;
    cyc(2);
    check(16'(baud), 16'h1);
    bsel = 2'b10;
    bset = 1'b1;
    cyc(1);
    bset = 1'b0;
    cyc(2);
    check(16'(baud), 16'h2);
    // raw mode: no init, every sample sent, rain forced to zero
    mode = 2'b10;
    rxdiv = 16'd2;
    run = 1'b1;
    cyc(2);
    sample(10'd45);
    expect_text(rep(0, 3, 14, 5, 7, 45, 0, 270, 0, 0));
    dir = 10'h3ff; // over range clamps
    sample(10'd0);
    expect_text(rep(0, 3, 14, 5, 7, 0, 0, 999, 0, 0));
    dir = 10'd270;
    run = 1'b0;
    // emulation mode: nothing leaves this block
    mode = 2'b11;
    cyc(2);
    run = 1'b1;
    sample(10'd5);
    sample(10'd6);
    cyc(200);
    check(16'(rxq.size()), 16'h0);
    run = 1'b0;
    mode = 2'b00;
    boot(1'b1, 1'b0); // gauge fitted, no button
    check(16'(tbtn), 16'h0);
    check(16'(rmiss), 16'h0);
    pulse_rerr();
    check(16'(rerrs), 16'h1);
    {mon, day, hr, mn} = {4'd12, 5'd31, 5'd23, 6'd59};
    stime = 1'b1;
    cyc(1);
    stime = 1'b0;
    rxdiv = 16'd4;
    cyc(2);
    run = 1'b1;
    expect_text({"\015\003MONITOR OFF\015ECHO OFF\015CONVERS\015", "WEATHER START 1.00.0\015"});
    period();
    expect_text(rep(1, 12, 31, 23, 59, 29, 59, 270, 12, 3));
    // aux mode: same report, no init, slower default rate
    run = 1'b0;
    mode = 2'b01;
    rxdiv = 16'd8;
    // one minute tick at 23:59 rolls minute and hour, date left alone
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(3);
    run = 1'b1;
    cyc(2);
    check(16'(busy), 16'h0);
    period();
    expect_text(rep(1, 12, 31, 0, 0, 29, 59, 270, 12, 3));
    tally_and_finish();
  end
endmodule
`default_nettype wire
